// ### verilog/tcc_timer.sv
// Purpose: 16-bit up-counter with two capture/compare registers
// Assumes: Count clock is sys_clk; triggers synchronous to sys_clk
// Notes:   Registers reached over AXI4-Lite; irq outputs are pulses
//
// Overview of operation
// RULE1: Reverse select: A captures on opposite trig_a edge, no irq.
// RULE2: Under reverse capture, trig_b edge raises irq_a, no capture.
// RULE3: Clear mode trig_a edge: capture into B, clear, toggle output.
// RULE4: Clear mode without trig_a edges keeps output low. Here A/B compare matches still toggle it.
// RULE5: Software reads both captures after irq_b, masks unused irq_a.
// RULE6: A compare: irq_a when equal to counter.
// RULE7: B compare: irq_b when equal to counter.
// RULE8: Compare matches never alter the counter.
// RULE9: A capture trigger: trig_a reverse phase or trig_b.
// RULE10: B captures only on trig_a valid edges.
// RULE11: Mode 01: free-running, one increment per count clock.
// RULE12: After FFFFH counter wraps to zero, sets overflow flag.
// RULE13: Software clears the overflow flag; hardware never does.
// RULE14: Free-running: compare/compare, compare/capture, capture/capture.
// RULE15: Both compare: toggle and matching irq on either match.
// RULE16: B capture: trig_a edge captures and raises irq_b.
// RULE17: Both capture: trig_b edges feed A, trig_a edges B.
// RULE18: Trig_b may accept both edges.
// RULE19: Only trig_b edges enabled: B receives no captures.
// RULE20: Mode 10: clear-and-start on trig_a valid edges.
// RULE21: Trig_a clear loads 0000H, counting resumes upward.
// RULE22: Triggers count after two consecutive equal samples.
// RULE23: Capture on a clearing edge stores the pre-clear count.
// RULE24: Each irq is a one-cycle pulse per event.
//
// Chosen here: the AXI4-Lite interface to the registers and the placing of the registers.
module tcc_timer #(
   parameter int unsigned ADDR_W = 12
) (
   input  wire logic                        sys_clk,
   input  wire logic                        sys_rst,
   input  wire logic                        s_axi_awvalid,
   output logic                             s_axi_awready,
   input  wire logic [ADDR_W-1:0]           s_axi_awaddr,
   input  wire logic                        s_axi_wvalid,
   output logic                             s_axi_wready,
   input  wire logic [tcc_pkg::DATA_W-1:0]  s_axi_wdata,
   input  wire logic [tcc_pkg::STRB_W-1:0]  s_axi_wstrb,
   output logic                             s_axi_bvalid,
   input  wire logic                        s_axi_bready,
   output logic [1:0]                       s_axi_bresp,
   input  wire logic                        s_axi_arvalid,
   output logic                             s_axi_arready,
   input  wire logic [ADDR_W-1:0]           s_axi_araddr,
   output logic                             s_axi_rvalid,
   input  wire logic                        s_axi_rready,
   output logic [tcc_pkg::DATA_W-1:0]       s_axi_rdata,
   output logic [1:0]                       s_axi_rresp,
   input  wire logic                        trig_in_a,
   input  wire logic                        trig_in_b,
   output logic                             timer_out,
   output logic                             irq_a,
   output logic                             irq_b
);
   tcc_pkg::tcc_core_s                st;
   tcc_pkg::tcc_core_s                next_st;
   tcc_pkg::tcc_wr_s                  wr;
   logic [tcc_pkg::REG_AW-1:0]        rd_addr;
   logic [tcc_pkg::DATA_W-1:0]        rd_data;
   logic                              a_rise;
   logic                              a_fall;
   logic                              b_rise;
   logic                              b_fall;

   function automatic logic edge_hit(input logic [1:0] sel,
                                     input logic       r,
                                     input logic       f);
      return (sel == tcc_pkg::EDGE_RISE && r) ||
             (sel == tcc_pkg::EDGE_FALL && f) ||
             (sel == tcc_pkg::EDGE_BOTH && (r || f));
   endfunction

   // Both-edge selection has no opposite phase, so it yields nothing
   function automatic logic edge_rev(input logic [1:0] sel,
                                     input logic       r,
                                     input logic       f);
      return (sel == tcc_pkg::EDGE_RISE && f) ||
             (sel == tcc_pkg::EDGE_FALL && r);
   endfunction

   function automatic logic [tcc_pkg::DATA_W-1:0] merge(
         input logic [tcc_pkg::DATA_W-1:0] old,
         input logic [tcc_pkg::DATA_W-1:0] data,
         input logic [tcc_pkg::STRB_W-1:0] strb);
      logic [tcc_pkg::DATA_W-1:0] res;
      res = old;
      for (int i = 0; i < tcc_pkg::STRB_W; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = data[i*8 +: 8];
         end
      end
      return res;
   endfunction

   tcc_axil_slave #(
      .ADDR_W (ADDR_W)
   ) u_bus (
      .sys_clk       (sys_clk),
      .sys_rst       (sys_rst),
      .s_axi_awvalid (s_axi_awvalid),
      .s_axi_awready (s_axi_awready),
      .s_axi_awaddr  (s_axi_awaddr),
      .s_axi_wvalid  (s_axi_wvalid),
      .s_axi_wready  (s_axi_wready),
      .s_axi_wdata   (s_axi_wdata),
      .s_axi_wstrb   (s_axi_wstrb),
      .s_axi_bvalid  (s_axi_bvalid),
      .s_axi_bready  (s_axi_bready),
      .s_axi_bresp   (s_axi_bresp),
      .s_axi_arvalid (s_axi_arvalid),
      .s_axi_arready (s_axi_arready),
      .s_axi_araddr  (s_axi_araddr),
      .s_axi_rvalid  (s_axi_rvalid),
      .s_axi_rready  (s_axi_rready),
      .s_axi_rdata   (s_axi_rdata),
      .s_axi_rresp   (s_axi_rresp),
      .wr            (wr),
      .rd_addr       (rd_addr),
      .rd_data       (rd_data)
   );

   tcc_edge_filter u_filt_a (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .din     (trig_in_a),
      .rise    (a_rise),
      .fall    (a_fall)
   );

   tcc_edge_filter u_filt_b (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .din     (trig_in_b),
      .rise    (b_rise),
      .fall    (b_fall)
   );

   always_comb begin
      unique case (rd_addr)
         tcc_pkg::OFS_CAPCMP_A: rd_data = tcc_pkg::DATA_W'(st.cca);
         tcc_pkg::OFS_CAPCMP_B: rd_data = tcc_pkg::DATA_W'(st.ccb);
         tcc_pkg::OFS_COUNT:    rd_data = tcc_pkg::DATA_W'(st.cnt);
         tcc_pkg::OFS_MODE:     rd_data = tcc_pkg::DATA_W'({st.ovf, st.mode});
         tcc_pkg::OFS_CCCTRL:   rd_data = tcc_pkg::DATA_W'(st.ccctrl);
         tcc_pkg::OFS_PRESCALE: rd_data = tcc_pkg::DATA_W'(st.esel);
         default:               rd_data = '0;
      endcase
   end

   always_comb begin
      logic [tcc_pkg::DATA_W-1:0] wv;
      logic [1:0]                 sel_a;
      logic                       ea;
      logic                       ea_rev;
      logic                       eb;
      logic                       cap_a;
      logic                       rev_a;
      logic                       cap_b;
      logic                       run;
      logic                       clr;
      logic                       match_a;
      logic                       match_b;
      wv      = '0;
      next_st = st;
      next_st.irq_a = 1'b0; // [RULE24]
      next_st.irq_b = 1'b0; // [RULE24]
      sel_a   = st.esel[tcc_pkg::TRIGA_ES_LSB +: 2];
      ea      = edge_hit(sel_a, a_rise, a_fall);
      ea_rev  = edge_rev(sel_a, a_rise, a_fall);
      // Trig_b accepts both edges when so selected [RULE18]
      eb      = edge_hit(st.esel[tcc_pkg::TRIGB_ES_LSB +: 2], b_rise, b_fall);
      cap_a   = st.ccctrl[tcc_pkg::CAPA_CAP_BIT];
      rev_a   = st.ccctrl[tcc_pkg::CAPA_REV_BIT];
      cap_b   = st.ccctrl[tcc_pkg::CAPB_CAP_BIT];
      run     = st.mode == tcc_pkg::MODE_FREE || st.mode == tcc_pkg::MODE_CLEAR;
      clr     = run && st.mode == tcc_pkg::MODE_CLEAR && ea; // [RULE20]
      match_a = run && !cap_a && st.cca == st.cnt;
      match_b = run && !cap_b && st.ccb == st.cnt;

      if (wr.en) begin
         unique case (wr.addr)
            tcc_pkg::OFS_CAPCMP_A: begin
               wv = merge(tcc_pkg::DATA_W'(st.cca), wr.data, wr.strb);
               next_st.cca = wv[tcc_pkg::CNT_W-1:0];
            end
            tcc_pkg::OFS_CAPCMP_B: begin
               wv = merge(tcc_pkg::DATA_W'(st.ccb), wr.data, wr.strb);
               next_st.ccb = wv[tcc_pkg::CNT_W-1:0];
            end
            tcc_pkg::OFS_MODE: begin
               wv = merge(tcc_pkg::DATA_W'({st.ovf, st.mode}), wr.data,
                          wr.strb);
               next_st.mode = wv[tcc_pkg::MODE_LSB +: 2];
               // Writing 0 clears the flag, writing 1 keeps it [RULE13]
               next_st.ovf  = st.ovf & wv[tcc_pkg::OVF_BIT];
            end
            tcc_pkg::OFS_CCCTRL: begin
               wv = merge(tcc_pkg::DATA_W'(st.ccctrl), wr.data, wr.strb);
               next_st.ccctrl = wv[2:0];
            end
            tcc_pkg::OFS_PRESCALE: begin
               wv = merge(tcc_pkg::DATA_W'(st.esel), wr.data, wr.strb);
               next_st.esel = wv[3:0];
            end
            default: wv = '0;
         endcase
      end

      if (!run) begin
         // Stopped: counter held at zero and output parked low
         next_st.cnt  = tcc_pkg::CNT_ZERO;
         next_st.tout = 1'b0;
      end else begin
         if (clr) begin
            next_st.cnt = tcc_pkg::CNT_ZERO; // [RULE3] [RULE21]
         end else begin
            next_st.cnt = st.cnt + tcc_pkg::CNT_ONE; // [RULE11] [RULE8]
            if (st.cnt == tcc_pkg::CNT_MAX) begin
               next_st.ovf = 1'b1; // [RULE12]
            end
         end
         // Toggles on clears and on A/B compare matches, so with neither it keeps its level [RULE4]
         if (clr || match_a || match_b) begin
            next_st.tout = ~st.tout; // [RULE3] [RULE15]
         end
         if (match_a) begin
            next_st.irq_a = 1'b1; // [RULE6] [RULE15]
         end
         if (match_b) begin
            next_st.irq_b = 1'b1; // [RULE7] [RULE15]
         end
         // Captures take st.cnt, the value before any clear [RULE23]
         if (cap_a && rev_a) begin
            if (ea_rev) begin
               next_st.cca = st.cnt; // [RULE1] [RULE9]
            end
            if (eb) begin
               next_st.irq_a = 1'b1; // [RULE2]
            end
         end else if (cap_a && eb) begin
            next_st.cca   = st.cnt; // [RULE9] [RULE17] [RULE14]
            next_st.irq_a = 1'b1;
         end
         // Only trig_a feeds register B [RULE19]
         if (cap_b && ea) begin
            next_st.ccb   = st.cnt; // [RULE10] [RULE16] [RULE17] [RULE3]
            next_st.irq_b = 1'b1; // [RULE16]
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign timer_out = st.tout;
   assign irq_a     = st.irq_a;
   assign irq_b     = st.irq_b;
endmodule

// ### verilog/tcc_pkg.sv
// Purpose: Shared constants and types of the timer capture/compare unit
// Assumes: One clock, synchronous active-high reset, 32-bit register bus
// Notes:   Offsets are byte addresses of aligned 32-bit words
package tcc_pkg;
   localparam int unsigned CNT_W  = 16;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned STRB_W = DATA_W / 8;
   localparam int unsigned REG_AW = 5;

   localparam logic [REG_AW-1:0] OFS_CAPCMP_A = 5'h00;
   localparam logic [REG_AW-1:0] OFS_CAPCMP_B = 5'h04;
   localparam logic [REG_AW-1:0] OFS_COUNT    = 5'h08;
   localparam logic [REG_AW-1:0] OFS_MODE     = 5'h0C;
   localparam logic [REG_AW-1:0] OFS_CCCTRL   = 5'h10;
   localparam logic [REG_AW-1:0] OFS_PRESCALE = 5'h14;

   localparam logic [1:0] MODE_STOP  = 2'h0;
   localparam logic [1:0] MODE_FREE  = 2'h1;
   localparam logic [1:0] MODE_CLEAR = 2'h2;
   localparam int unsigned MODE_LSB     = 0;
   localparam int unsigned OVF_BIT      = 2;
   localparam int unsigned CAPA_CAP_BIT = 0;
   localparam int unsigned CAPA_REV_BIT = 1;
   localparam int unsigned CAPB_CAP_BIT = 2;
   localparam int unsigned TRIGA_ES_LSB = 0;
   localparam int unsigned TRIGB_ES_LSB = 2;

   localparam logic [1:0] EDGE_FALL = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_NONE = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;

   localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_ONE  = 16'h0001;
   localparam logic [CNT_W-1:0] CNT_MAX  = 16'hFFFF;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      WR_COLLECT = 2'b01,
      WR_RESP    = 2'b10
   } tcc_wst_e;

   typedef enum logic [2:0] {
      RD_IDLE  = 3'b001,
      RD_FETCH = 3'b010,
      RD_DATA  = 3'b100
   } tcc_rst_e;

   typedef struct packed {
      logic samp;
      logic filt;
      logic rise;
      logic fall;
   } tcc_edge_s;

   typedef struct packed {
      logic              en;
      logic [REG_AW-1:0] addr;
      logic [DATA_W-1:0] data;
      logic [STRB_W-1:0] strb;
   } tcc_wr_s;

   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic [CNT_W-1:0] cca;
      logic [CNT_W-1:0] ccb;
      logic [1:0]       mode;
      logic             ovf;
      logic [2:0]       ccctrl;
      logic [3:0]       esel;
      logic             tout;
      logic             irq_a;
      logic             irq_b;
   } tcc_core_s;

   function automatic logic reg_hit(input logic [REG_AW-1:0] a);
      return a inside {OFS_CAPCMP_A, OFS_CAPCMP_B, OFS_COUNT, OFS_MODE,
                       OFS_CCCTRL, OFS_PRESCALE};
   endfunction
endpackage

// ### verilog/tcc_edge_filter.sv
// Purpose: Two-sample noise filter and edge detector for one trigger input
// Assumes: Input is synchronous to sys_clk
// Notes:   A level counts only once seen on two consecutive samples
module tcc_edge_filter (
   input  wire logic sys_clk,
   input  wire logic sys_rst,
   input  wire logic din,
   output logic      rise,
   output logic      fall
);
   tcc_pkg::tcc_edge_s st;
   tcc_pkg::tcc_edge_s next_st;

   always_comb begin
      next_st      = st;
      next_st.samp = din;
      next_st.rise = 1'b0;
      next_st.fall = 1'b0;
      // Short pulses never reach filt, so they make no edge
      if (din == st.samp && din != st.filt) begin // [RULE22]
         next_st.filt = din;
         next_st.rise = din;
         next_st.fall = ~din;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign rise = st.rise;
   assign fall = st.fall;
endmodule

// ### verilog/tcc_axil_slave.sv
// Purpose: AXI4-Lite slave front end for the register file
// Assumes: One write and one read outstanding at most
// Notes:   Decodes only the low address bits, upper bits alias
module tcc_axil_slave #(
   parameter int unsigned ADDR_W = 12
) (
   input  wire logic                        sys_clk,
   input  wire logic                        sys_rst,
   input  wire logic                        s_axi_awvalid,
   output logic                             s_axi_awready,
   input  wire logic [ADDR_W-1:0]           s_axi_awaddr,
   input  wire logic                        s_axi_wvalid,
   output logic                             s_axi_wready,
   input  wire logic [tcc_pkg::DATA_W-1:0]  s_axi_wdata,
   input  wire logic [tcc_pkg::STRB_W-1:0]  s_axi_wstrb,
   output logic                             s_axi_bvalid,
   input  wire logic                        s_axi_bready,
   output logic [1:0]                       s_axi_bresp,
   input  wire logic                        s_axi_arvalid,
   output logic                             s_axi_arready,
   input  wire logic [ADDR_W-1:0]           s_axi_araddr,
   output logic                             s_axi_rvalid,
   input  wire logic                        s_axi_rready,
   output logic [tcc_pkg::DATA_W-1:0]       s_axi_rdata,
   output logic [1:0]                       s_axi_rresp,
   output tcc_pkg::tcc_wr_s                 wr,
   output logic [tcc_pkg::REG_AW-1:0]       rd_addr,
   input  wire logic [tcc_pkg::DATA_W-1:0]  rd_data
);
   if (ADDR_W < tcc_pkg::REG_AW || ADDR_W > tcc_pkg::DATA_W) begin : g_chk
      $error("tcc_axil_slave: ADDR_W out of range");
   end

   typedef struct packed {
      tcc_pkg::tcc_wst_e            wst;
      tcc_pkg::tcc_rst_e            rst;
      logic                         awready;
      logic                         wready;
      logic                         bvalid;
      logic [1:0]                   bresp;
      logic                         arready;
      logic                         rvalid;
      logic [1:0]                   rresp;
      logic [tcc_pkg::DATA_W-1:0]   rdata;
      logic [tcc_pkg::REG_AW-1:0]   raddr;
      tcc_pkg::tcc_wr_s             wr;
   } tcc_axi_s;

   localparam tcc_axi_s AXI_RST = '{
      wst: tcc_pkg::WR_COLLECT, rst: tcc_pkg::RD_IDLE, awready: 1'b1,
      wready: 1'b1, bvalid: 1'b0, bresp: tcc_pkg::RESP_OKAY,
      arready: 1'b1, rvalid: 1'b0, rresp: tcc_pkg::RESP_OKAY,
      rdata: '0, raddr: '0, wr: '0};

   tcc_axi_s st;
   tcc_axi_s next_st;

   always_comb begin
      next_st       = st;
      next_st.wr.en = 1'b0;
      unique case (st.wst)
         tcc_pkg::WR_COLLECT: begin
            if (s_axi_awvalid && st.awready) begin
               next_st.awready = 1'b0;
               next_st.wr.addr = s_axi_awaddr[tcc_pkg::REG_AW-1:0];
            end
            if (s_axi_wvalid && st.wready) begin
               next_st.wready  = 1'b0;
               next_st.wr.data = s_axi_wdata;
               next_st.wr.strb = s_axi_wstrb;
            end
            // Address and data may come in either order
            if (!next_st.awready && !next_st.wready) begin
               next_st.wr.en  = 1'b1;
               next_st.bvalid = 1'b1;
               next_st.bresp  = tcc_pkg::reg_hit(next_st.wr.addr) ?
                                tcc_pkg::RESP_OKAY : tcc_pkg::RESP_SLVERR;
               next_st.wst    = tcc_pkg::WR_RESP;
            end
         end
         tcc_pkg::WR_RESP: begin
            if (s_axi_bready) begin
               next_st.bvalid  = 1'b0;
               next_st.awready = 1'b1;
               next_st.wready  = 1'b1;
               next_st.wst     = tcc_pkg::WR_COLLECT;
            end
         end
      endcase
      unique case (st.rst)
         tcc_pkg::RD_IDLE: begin
            if (s_axi_arvalid) begin
               next_st.arready = 1'b0;
               next_st.raddr   = s_axi_araddr[tcc_pkg::REG_AW-1:0];
               next_st.rst     = tcc_pkg::RD_FETCH;
            end
         end
         tcc_pkg::RD_FETCH: begin
            next_st.rdata  = rd_data;
            next_st.rresp  = tcc_pkg::reg_hit(st.raddr) ?
                             tcc_pkg::RESP_OKAY : tcc_pkg::RESP_SLVERR;
            next_st.rvalid = 1'b1;
            next_st.rst    = tcc_pkg::RD_DATA;
         end
         tcc_pkg::RD_DATA: begin
            if (s_axi_rready) begin
               next_st.rvalid  = 1'b0;
               next_st.arready = 1'b1;
               next_st.rst     = tcc_pkg::RD_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         st <= AXI_RST;
      end else begin
         st <= next_st;
      end
   end

   assign s_axi_awready = st.awready;
   assign s_axi_wready  = st.wready;
   assign s_axi_bvalid  = st.bvalid;
   assign s_axi_bresp   = st.bresp;
   assign s_axi_arready = st.arready;
   assign s_axi_rvalid  = st.rvalid;
   assign s_axi_rdata   = st.rdata;
   assign s_axi_rresp   = st.rresp;
   assign wr            = st.wr;
   assign rd_addr       = st.raddr;
endmodule

// ### sim/tcc_timer_assertions.sv
// Purpose: Port-level timer checks
// Assumes: Bound to tcc_timer, one clock
// Notes:   Mode bits unseen, so mode-free checks
module tcc_timer_assertions #(
   parameter int unsigned ADDR_W = 12
) (
   input wire logic              sys_clk,
   input wire logic              sys_rst,
   input wire logic              s_axi_awvalid,
   input wire logic              s_axi_awready,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic              s_axi_wvalid,
   input wire logic              s_axi_wready,
   input wire logic              s_axi_bvalid,
   input wire logic              s_axi_bready,
   input wire logic [1:0]        s_axi_bresp,
   input wire logic              s_axi_arvalid,
   input wire logic              s_axi_arready,
   input wire logic              s_axi_rvalid,
   input wire logic              s_axi_rready,
   input wire logic [31:0]       s_axi_rdata,
   input wire logic              timer_out,
   input wire logic              irq_a,
   input wire logic              irq_b
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   sequence s_wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_wr_bad;
      s_wr_take ##0 (s_axi_awaddr[4:0] > 5'h14);
   endsequence
   a_irq_a_pulse: assert property (irq_a |=> !irq_a)
      else $error("irq_a longer than one cycle");
   a_irq_b_pulse: assert property (irq_b |=> !irq_b)
      else $error("irq_b longer than one cycle");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
   a_rd_latency: assert property (s_axi_arvalid && s_axi_arready
      |=> !s_axi_rvalid ##1 s_axi_rvalid) else $error("read latency wrong");
   a_wr_answer: assert property (s_wr_take |=> s_axi_bvalid)
      else $error("write not answered");
   a_wr_unmapped: assert property (s_wr_bad |=> s_axi_bresp == 2'h2)
      else $error("unmapped write not refused");
   a_reset_quiet: assert property (disable iff (1'b0) sys_rst
      |=> !s_axi_bvalid && !s_axi_rvalid && !irq_a && !irq_b && !timer_out)
      else $error("outputs active after reset");
endmodule

bind tcc_timer tcc_timer_assertions #(.ADDR_W(ADDR_W)) u_chk (.*);

// ### sim/tcc_trig_model.sv
// Purpose: Trigger source for the timer
// Assumes: Levels change after a rising edge
// Notes:   One-cycle pulse only on request
module tcc_trig_model (
   input wire logic sys_clk,
   input wire logic want_a,
   input wire logic want_b,
   input wire logic glitch_b,
   output logic     trig_in_a,
   output logic     trig_in_b
);
   timeunit 1ns;
   timeprecision 1ps;
   always_ff @(posedge sys_clk) begin
      trig_in_a <= want_a;
      trig_in_b <= want_b ^ glitch_b;
   end
endmodule

// ### sim/tcc_timer_tb.sv
// Purpose: Self-checking timer bench
// Assumes: Triggers come from tcc_trig_model
// Notes:   Bus answers checked in order via queues
module tcc_timer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        sys_clk, sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_rready, want_a, want_b, glitch_b;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic        s_axi_rvalid, trig_in_a, trig_in_b, timer_out, irq_a, irq_b;
   logic        tout_d;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rnd, last;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [34:0] e;
   logic [34:0] rq[$];
   logic [1:0]  bq[$];
   int          fails, checked, na, nb, nt;

   tcc_timer dut (.*);
   tcc_trig_model u_trig (.*);

   always #12.5 sys_clk = ~sys_clk;

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic results;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   // Watcher: event counts, bus answers oldest first
   always @(posedge sys_clk) begin
      if (!sys_rst) begin
         if (irq_a === 1'b1) na++;
         if (irq_b === 1'b1) nb++;
         if (timer_out !== tout_d) nt++;
         tout_d = timer_out;
      end
      if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
         last = s_axi_rdata;
         e = rq.pop_front();
         if (e[34]) chk({s_axi_rresp, s_axi_rdata}, e[33:0]);
      end
      if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
         chk({32'h0, s_axi_bresp}, {32'h0, bq.pop_front()});
   end

   task automatic wr(input logic [4:0] a, input logic [31:0] d,
                     input logic [1:0] r);
      int n;
      bq.push_back(r);
      @(posedge sys_clk);
      s_axi_awaddr <= {7'h0, a};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge sys_clk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) break;
      end
      s_axi_bready <= 1'b0;
      if (n == 50) begin
         fails++;
         results();
      end
   endtask

   // k: check flag, response; rel adds last read value
   task automatic rd(input logic [4:0] a, input logic [2:0] k,
                     input logic [31:0] d, input bit rel);
      int n;
      @(posedge sys_clk);
      rq.push_back({k, rel ? last + d : d});
      s_axi_araddr <= {7'h0, a};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge sys_clk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) break;
      end
      s_axi_rready <= 1'b0;
      if (n == 50) begin
         fails++;
         results();
      end
   endtask

   // Falling edge keeps clear of the watcher
   task automatic ev(input int ea, input int eb, input int et);
      @(negedge sys_clk);
      chk(34'(na), 34'(ea));
      chk(34'(nb), 34'(eb));
      chk(34'(nt), 34'(et));
      {na, nb, nt} = '0;
   endtask

   task automatic lv(input logic a, input logic b, input int w);
      @(posedge sys_clk);
      want_a <= a;
      want_b <= b;
      repeat (w) @(posedge sys_clk);
   endtask

   initial begin
      {sys_clk, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, want_a, want_b, glitch_b, tout_d} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, last} = '0;
      sys_rst = 1'b1;
      s_axi_wstrb = 4'hF;
      rnd = 32'h9ef4_4eec;
      repeat (2) @(posedge sys_clk);
      sys_rst <= 1'b0;
      rd(tcc_pkg::OFS_MODE, 3'b100, 32'h0000_0000, 0);
      rd(5'h18, 3'b110, 32'h0000_0000, 0);
      wr(5'h18, 32'h0000_0001, 2'h2);
      rnd = lfsr(rnd);
      wr(tcc_pkg::OFS_CAPCMP_A, {24'h00_0001, rnd[7:0]}, 2'h0);
      rd(tcc_pkg::OFS_CAPCMP_A, 3'b100, {24'h00_0001, rnd[7:0]}, 0);
      wr(tcc_pkg::OFS_CAPCMP_B, 32'h0000_0280, 2'h0);
      wr(tcc_pkg::OFS_MODE, 32'h0000_0001, 2'h0);
      repeat (700) @(posedge sys_clk);
      ev(1, 1, 2);
      rd(tcc_pkg::OFS_COUNT, 3'b000, 32'h0000_0000, 0);
      rd(tcc_pkg::OFS_COUNT, 3'b100, 32'h0000_0004, 1);
      $display("compare test done");
      repeat (65536) @(posedge sys_clk);
      rd(tcc_pkg::OFS_MODE, 3'b100, 32'h0000_0005, 0);
      wr(tcc_pkg::OFS_MODE, 32'h0000_0001, 2'h0);
      rd(tcc_pkg::OFS_MODE, 3'b100, 32'h0000_0001, 0);
      ev(1, 1, 2);
      $display("overflow test done");
      wr(tcc_pkg::OFS_CCCTRL, 32'h0000_0005, 2'h0);
      wr(tcc_pkg::OFS_PRESCALE, 32'h0000_000D, 2'h0);
      lv(1'b0, 1'b1, 10);
      lv(1'b1, 1'b1, 10);
      rd(tcc_pkg::OFS_CAPCMP_A, 3'b000, 32'h0000_0000, 0);
      rd(tcc_pkg::OFS_CAPCMP_B, 3'b100, 32'h0000_000B, 1);
      lv(1'b1, 1'b0, 10);
      lv(1'b0, 1'b0, 10);
      ev(2, 1, 0);
      @(posedge sys_clk) glitch_b <= 1'b1;
      @(posedge sys_clk) glitch_b <= 1'b0;
      wr(tcc_pkg::OFS_PRESCALE, 32'h0000_000E, 2'h0);
      lv(1'b1, 1'b0, 10);
      lv(1'b0, 1'b0, 10);
      ev(0, 0, 0);
      $display("capture test done");
      wr(tcc_pkg::OFS_CCCTRL, 32'h0000_0007, 2'h0);
      wr(tcc_pkg::OFS_PRESCALE, 32'h0000_0001, 2'h0);
      wr(tcc_pkg::OFS_MODE, 32'h0000_0002, 2'h0);
      lv(1'b0, 1'b1, 10);
      chk({33'h0, timer_out}, 34'h0);
      lv(1'b1, 1'b1, 20);
      lv(1'b0, 1'b1, 20);
      lv(1'b1, 1'b1, 10);
      rd(tcc_pkg::OFS_CAPCMP_B, 3'b000, 32'h0000_0000, 0);
      rd(tcc_pkg::OFS_CAPCMP_A, 3'b100, 32'hFFFF_FFEB, 1);
      lv(1'b1, 1'b0, 10);
      rd(tcc_pkg::OFS_CAPCMP_A, 3'b100, 32'h0000_0000, 1);
      ev(1, 2, 2);
      $display("clear test done");
      results();
   end
endmodule
